// ===== src/ffa_datapath.sv
// Fixed and floating point arithmetic datapath
`timescale 1ns/1ns
`include "ffa_consts.svh"

module ffa_datapath
  import ffa_pkg::*;
#(
  parameter int DW = `FFA_DBL_W
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire ffa_op_e op,
  input wire ffa_prec_e prec,
  input wire logic is_signed,
  input wire logic [`FFA_WORD_W-1:0] instr_word,
  input wire logic [DW-1:0] opnd_a,
  input wire logic [DW-1:0] opnd_b,
  output logic [DW-1:0] result_q,
  output ffa_flags_s flags_q,
  output ffa_instr_s instr_q,
  output logic done_q
);
  // --------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------
  // Bits 27 and 29 are ignored; software keeps them zero
  wire ffa_instr_s dec = '{
    addr: instr_word[`FFA_WORD_W-1 -: `FFA_HALF_W],
    opcode: instr_word[`FFA_WORD_W-1-`FFA_OP_LSB -: (`FFA_OP_MSB-`FFA_OP_LSB+1)],
    inhibit: instr_word[`FFA_WORD_W-1-`FFA_INH_BIT],
    tag: instr_word[`FFA_WORD_W-1-`FFA_TAG_LSB -: (`FFA_TAG_MSB-`FFA_TAG_LSB+1)]
  };
  // Shift count uses the low 7 address bits; higher bits are dropped, so counts of 128 and up wrap
  // Bit 0 is the leftmost bit, so instruction bit n sits at vector bit 35-n
  wire logic [`FFA_SHCNT_W-1:0] sh_cnt = dec.addr[`FFA_SHCNT_W-1:0];

  // --------------------------------------------------------------
  // Fixed-point adder
  // --------------------------------------------------------------
  // Operands are right-justified; width picks which carry is the MSB carry
  function automatic int unsigned prec_w(input ffa_prec_e p);
    case (p)
      FFA_HALF: prec_w = `FFA_HALF_W;
      FFA_SINGLE: prec_w = `FFA_WORD_W;
      default: prec_w = `FFA_DBL_W;
    endcase
  endfunction : prec_w

  wire logic is_sub = (op == FFA_OP_SUB) || (op == FFA_OP_CMP);
  // Complement and carry-in of one are applied for subtract and compare only, even for zero
  wire logic [DW-1:0] b_eff = is_sub ? ~opnd_b : opnd_b;
  wire logic [DW:0] full_sum = {1'b0, opnd_a} + {1'b0, b_eff} +
                               {{DW{1'b0}}, is_sub};
  // Carry chain per bit: carry into bit i is sum xor a xor b
  wire logic [DW-1:0] cin_vec = full_sum[DW-1:0] ^ opnd_a ^ b_eff;
  wire logic [6:0] w = 7'(prec_w(prec));
  // Half and single results ignore the bits above their width
  wire logic [DW-1:0] mask = (w >= DW) ? {DW{1'b1}} : ((DW'(1) << w) - DW'(1));
  wire logic [DW-1:0] fx_res = full_sum[DW-1:0] & mask;
  wire logic c_out = (w >= DW) ? full_sum[DW] : cin_vec[w[6:0]];
  wire logic c_in_sign = cin_vec[w[6:0] - 7'd1];
  wire logic r_sign = fx_res[w[6:0] - 7'd1];
  wire logic s_ovf = c_in_sign ^ c_out;
  wire logic r_zero = (fx_res == '0);

  // --------------------------------------------------------------
  // Floating-point align, add and normalize
  // --------------------------------------------------------------
  // Layout in the 72-bit carrier: exponent top 8, mantissa next 64
  localparam int MW = `FFA_MANT_W;
  wire logic signed [7:0] ea = opnd_a[DW-1 -: `FFA_EXP_W];
  wire logic signed [7:0] eb = opnd_b[DW-1 -: `FFA_EXP_W];
  wire logic signed [MW-1:0] ma = opnd_a[MW-1:0];
  wire logic signed [MW-1:0] mb_raw = opnd_b[MW-1:0];
  wire logic signed [MW-1:0] mb = (op == FFA_OP_FSUB) ? -mb_raw : mb_raw;
  wire logic a_big = (ea >= eb);
  wire logic [8:0] ediff = a_big ? 9'(ea - eb) : 9'(eb - ea);
  // Shifts past the mantissa width leave only sign copies, so cap the count
  wire logic [6:0] sh_al = (ediff > 9'(MW)) ? 7'(MW) : ediff[6:0];
  // Two extra sign bits keep the untruncated sum for the zero test
  // A concatenation is unsigned, so cast it before the arithmetic shift keeps the sign
  wire logic signed [MW+1:0] ma_x = $signed({{2{ma[MW-1]}}, ma});
  wire logic signed [MW+1:0] mb_x = $signed({{2{mb[MW-1]}}, mb});
  wire logic signed [MW+1:0] ax = a_big ? ma_x : (ma_x >>> sh_al);
  wire logic signed [MW+1:0] bx = a_big ? (mb_x >>> sh_al) : mb_x;
  wire logic signed [MW+1:0] fsum = (op == FFA_OP_FNORM) ? ma_x : ax + bx;
  wire logic signed [9:0] e_big = (op == FFA_OP_FNORM) ? 10'(ea) : (a_big ? 10'(ea) : 10'(eb));
  // Mantissa overflow: shift right once and bump the exponent
  wire logic m_ovf = fsum[MW] ^ fsum[MW-1];
  wire logic [MW-1:0] m1 = m_ovf ? fsum[MW:1] : fsum[MW-1:0];
  wire logic signed [9:0] e1 = m_ovf ? e_big + 10'sd1 : e_big;

  // Count of leading copies of the sign after the sign bit
  function automatic logic [6:0] lead_cnt(input logic [MW-1:0] m);
    logic [6:0] n;
    logic stop;
    n = '0;
    stop = 1'b0;
    for (int i = MW-2; i >= 0; i--)
    begin
      if (!stop && (m[i] == m[MW-1]))
        n = n + 7'd1;
      else
        stop = 1'b1;
    end
    lead_cnt = n;
  endfunction : lead_cnt

  wire logic [6:0] nsh = lead_cnt(m1);
  wire logic [MW-1:0] m_norm = m1 << nsh;
  wire logic signed [9:0] e_norm = e1 - 10'(nsh);
  wire logic f_zero = (fsum == '0);
  // Underflow flushes to the zero form rather than keeping a tiny value
  wire logic e_low = (e_norm < `FFA_EXP_MIN);
  // Exponent overflow wraps; only the flags tell software
  wire logic e_high = (e_norm > `FFA_EXP_MAX);
  // Normalized result has bit after sign opposite the sign
  wire logic [7:0] e_out = (f_zero || e_low) ? `FFA_EXP_ZERO : e_norm[7:0];
  wire logic [MW-1:0] m_out = (f_zero || e_low) ? '0 : m_norm;

  // --------------------------------------------------------------
  // Shifter and result select
  // --------------------------------------------------------------
  wire logic [DW-1:0] shl_res = (opnd_a << sh_cnt) & mask;
  wire logic [DW-1:0] shr_res = (opnd_a & mask) >> sh_cnt;
  wire logic is_float = (op == FFA_OP_FADD) || (op == FFA_OP_FSUB) || (op == FFA_OP_FNORM);
  // Shifts report zero and sign only; carry and range stay clear
  wire logic is_shift = (op == FFA_OP_SHL) || (op == FFA_OP_SHR);
  wire logic [DW-1:0] res_d = is_float ? {e_out, m_out} :
                              (op == FFA_OP_SHL) ? shl_res :
                              (op == FFA_OP_SHR) ? shr_res : fx_res;
  // Binary point is only a matter of interpretation; adder is shared

  ffa_flags_s fl_d;
  always_comb
  begin
    fl_d = '0;
    if (is_float)
    begin
      fl_d.zero = f_zero;
      fl_d.neg = m_out[MW-1];
      fl_d.ovf = e_high;
      fl_d.above = e_high;
      fl_d.below = e_low && !f_zero;
    end
    else if (is_shift)
    begin
      fl_d.zero = (res_d == '0);
      fl_d.neg = res_d[w[6:0] - 7'd1];
    end
    else
    begin
      fl_d.zero = r_zero;
      fl_d.carry = c_out;
      fl_d.neg = r_sign;
      if (is_signed)
      begin
        fl_d.ovf = s_ovf;
        fl_d.above = s_ovf && r_sign;
        fl_d.below = s_ovf && !r_sign;
      end
      else if (op == FFA_OP_ADD)
      begin
        fl_d.ovf = c_out;
        fl_d.above = c_out;
      end
      else if (op == FFA_OP_SUB)
      begin
        fl_d.ovf = !c_out;
        fl_d.below = !c_out;
      end
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Compare leaves the result register alone; flags and instr_q still load
  // Every start is taken, back to back too; done follows one cycle later
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result_q <= '0;
      flags_q <= '0;
      instr_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= start;
      if (start)
      begin
        if (op != FFA_OP_CMP)
          result_q <= res_d;
        flags_q <= fl_d;
        instr_q <= dec;
      end
    end
  end
endmodule : ffa_datapath

// ===== src/ffa_consts.svh
// Constants for the fixed and floating arithmetic datapath
`ifndef FFA_CONSTS_SVH
`define FFA_CONSTS_SVH
`define FFA_WORD_W 36
`define FFA_HALF_W 18
`define FFA_DBL_W 72
`define FFA_ADDR_MSB 17
`define FFA_OP_LSB 18
`define FFA_OP_MSB 26
`define FFA_INH_BIT 28
`define FFA_TAG_LSB 30
`define FFA_TAG_MSB 35
`define FFA_EXP_W 8
`define FFA_MANT_W 64
`define FFA_EXP_ZERO 8'h80
`define FFA_EXP_MIN (-10'sd128)
`define FFA_EXP_MAX 10'sd127
`define FFA_SHCNT_W 7
`endif

// ===== src/ffa_pkg.sv
// Types for the fixed and floating arithmetic datapath
package ffa_pkg;
  typedef enum logic [3:0] {
    FFA_OP_ADD, FFA_OP_SUB, FFA_OP_CMP, FFA_OP_FADD, FFA_OP_FSUB, FFA_OP_FNORM,
    FFA_OP_SHL, FFA_OP_SHR
  } ffa_op_e;
  typedef enum logic [1:0] {FFA_HALF, FFA_SINGLE, FFA_DOUBLE} ffa_prec_e;
  typedef struct packed {
    logic zero;
    logic neg;
    logic carry;
    logic ovf;
    logic above;
    logic below;
  } ffa_flags_s;
  typedef struct packed {
    logic [17:0] addr;
    logic [8:0] opcode;
    logic inhibit;
    logic [5:0] tag;
  } ffa_instr_s;
endpackage : ffa_pkg

// ===== test/ffa_datapath_sva.sv
// Port checker for the arithmetic datapath
`timescale 1ns/1ns
module ffa_datapath_sva
  import ffa_pkg::*;
#(
  parameter int DW = 72
)(
  input logic clk,
  input logic rstn,
  input logic start,
  input ffa_op_e op,
  input ffa_prec_e prec,
  input logic is_signed,
  input logic [35:0] instr_word,
  input logic [DW-1:0] opnd_a,
  input logic [DW-1:0] opnd_b,
  input logic [DW-1:0] result_q,
  input ffa_flags_s flags_q,
  input ffa_instr_s instr_q,
  input logic done_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_lone;
    start ##1 !start;
  endsequence
  a_done_pulse: assert property (s_lone |-> done_q ##1 !done_q)
    else $error("done not one pulse");
  a_no_done: assert property (!start |=> !done_q)
    else $error("done without start");
  a_flags_hold: assert property (!start |=> $stable(flags_q))
    else $error("flags moved idle");
  a_instr_dec: assert property (start |=> instr_q == $past({instr_word[35:9],
      instr_word[7], instr_word[5:0]})) else $error("decode wrong");
  a_uns_above: assert property (start && op == FFA_OP_ADD && !is_signed
      |=> flags_q.above == flags_q.carry) else $error("add range wrong");
  a_uns_below: assert property (start && op == FFA_OP_SUB && !is_signed
      |=> flags_q.below == !flags_q.carry) else $error("sub range wrong");
  a_sgn_range: assert property (start && is_signed && op inside {FFA_OP_ADD, FFA_OP_SUB}
      |=> flags_q.above == (flags_q.ovf && flags_q.neg)
      && flags_q.below == (flags_q.ovf && !flags_q.neg)) else $error("signed range wrong");
  a_sub_sum: assert property (start && op == FFA_OP_SUB && prec == FFA_SINGLE
      |=> result_q[35:0] == $past(opnd_a[35:0] + ~opnd_b[35:0] + 36'h1)) else $error("sub");
  a_float_zero: assert property (start && op inside {FFA_OP_FADD, FFA_OP_FSUB}
      |=> !flags_q.zero || result_q[71:64] == 8'h80) else $error("float zero");
  a_norm_form: assert property (start && op inside {FFA_OP_FADD, FFA_OP_FSUB, FFA_OP_FNORM}
      |=> flags_q.zero || flags_q.below || (result_q[63] != result_q[62]))
      else $error("float not normalized");
endmodule : ffa_datapath_sva
bind ffa_datapath ffa_datapath_sva #(.DW(DW)) u_sva (.clk(clk), .rstn(rstn), .start(start),
  .op(op), .prec(prec), .is_signed(is_signed), .instr_word(instr_word), .opnd_a(opnd_a),
  .opnd_b(opnd_b), .result_q(result_q), .flags_q(flags_q), .instr_q(instr_q), .done_q(done_q));

// ===== test/ffa_seq.sv
// Instruction sequencing model that issues datapath requests
`timescale 1ns/1ns
module ffa_seq
  import ffa_pkg::*;
(
  input logic clk,
  output logic start,
  output ffa_op_e op,
  output ffa_prec_e prec,
  output logic is_signed,
  output logic [35:0] instr_word,
  output logic [71:0] opnd_a,
  output logic [71:0] opnd_b
);
  initial
  begin
    start = 1'b0;
    op = FFA_OP_ADD;
    prec = FFA_HALF;
    is_signed = 1'b0;
    instr_word = '0;
    opnd_a = '0;
    opnd_b = '0;
  end
  // Operands stay put after the request so the answer edge still sees them
  task issue(input ffa_op_e o, input ffa_prec_e p, input logic s, input logic [71:0] a,
    input logic [71:0] b, input logic [35:0] iw);
    @(negedge clk);
    op = o;
    prec = p;
    is_signed = s;
    opnd_a = a;
    opnd_b = b;
    instr_word = iw & ~36'h140;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : issue
endmodule : ffa_seq

// ===== test/tb_ffa_datapath.sv
// Self-checking bench for the arithmetic datapath
`timescale 1ns/1ns
module tb_ffa_datapath;
  import ffa_pkg::*;
  logic clk, rstn, start, is_signed, done_q;
  ffa_op_e op;
  ffa_prec_e prec, pr;
  logic [35:0] instr_word;
  logic [71:0] opnd_a, opnd_b, result_q;
  ffa_flags_s flags_q;
  ffa_instr_s instr_q;
  int err_count, compares;
  ffa_seq p (.clk(clk), .start(start), .op(op), .prec(prec), .is_signed(is_signed),
    .instr_word(instr_word), .opnd_a(opnd_a), .opnd_b(opnd_b));
  ffa_datapath #(.DW(72)) uut (.clk(clk), .rstn(rstn), .start(start), .op(op), .prec(prec),
    .is_signed(is_signed), .instr_word(instr_word), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .result_q(result_q), .flags_q(flags_q), .instr_q(instr_q), .done_q(done_q));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task cw(input string n, input logic [71:0] e, input logic [71:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cw
  // Masked: flag meanings outside the rule under test are left open
  task cf(input logic [5:0] e, input logic [5:0] m);
    compares++;
    if ((flags_q & m) !== (e & m))
    begin
      err_count++;
      $display("[FAIL] flags expected %h seen %h", e & m, flags_q & m);
    end
  endtask : cf
  task run(input ffa_op_e o, input logic s, input logic [71:0] a, input logic [71:0] b,
    input logic [71:0] er, input logic [5:0] ef, input logic [5:0] m);
    p.issue(o, pr, s, a, b, 36'h0);
    cw("done", 72'h1, {71'h0, done_q});
    cw("result", er, result_q);
    cf(ef, m);
  endtask : run
  task complete_run;
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial
  begin
    #20000;
    err_count++;
    complete_run;
  end
  initial
  begin
    rstn = 1'b0;
    pr = FFA_SINGLE;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    run(FFA_OP_ADD, 1'b0, 72'hfffffffff, 72'h1, 72'h0, 6'h2e, 6'h3f);
    run(FFA_OP_ADD, 1'b0, 72'h5, 72'h3, 72'h8, 6'h00, 6'h2b);
    run(FFA_OP_SUB, 1'b0, 72'h3, 72'h5, 72'hffffffffe, 6'h01, 6'h2b);
    run(FFA_OP_SUB, 1'b0, 72'h5, 72'h0, 72'h5, 6'h08, 6'h2b);
    run(FFA_OP_CMP, 1'b0, 72'h5, 72'h5, 72'h5, 6'h28, 6'h28);
    run(FFA_OP_CMP, 1'b0, 72'h3, 72'h5, 72'h5, 6'h00, 6'h28);
    run(FFA_OP_ADD, 1'b1, 72'h7ffffffff, 72'h1, 72'h800000000, 6'h16, 6'h37);
    run(FFA_OP_SUB, 1'b1, 72'h800000000, 72'h1, 72'h7ffffffff, 6'h05, 6'h37);
    run(FFA_OP_ADD, 1'b1, 72'hfffffffff, 72'h1, 72'h0, 6'h20, 6'h37);
    pr = FFA_HALF;
    run(FFA_OP_ADD, 1'b0, 72'h3ffff, 72'h1, 72'h0, 6'h2a, 6'h2b);
    pr = FFA_DOUBLE;
    run(FFA_OP_ADD, 1'b0, {72{1'b1}}, 72'h1, 72'h0, 6'h2a, 6'h2b);
    run(FFA_OP_FADD, 1'b1, 72'h024 << 60, 72'h014 << 60, 72'h026 << 60, 6'h0, 6'h30);
    run(FFA_OP_FADD, 1'b1, 72'h024 << 60, 72'h01c << 60, 72'h014 << 60, 6'h0, 6'h30);
    run(FFA_OP_FSUB, 1'b1, 72'h024 << 60, 72'h024 << 60, 72'h80 << 64, 6'h20, 6'h20);
    run(FFA_OP_FNORM, 1'b1, 72'h070d << 56, 72'h0, 72'h0468 << 56, 6'h0, 6'h30);
    run(FFA_OP_FNORM, 1'b1, 72'h00f << 60, 72'h0, 72'hfd8 << 60, 6'h10, 6'h30);
    p.issue(FFA_OP_SHL, FFA_SINGLE, 1'b0, 72'h1, 72'h0, {18'h4, 18'h0});
    cw("shl", 72'h10, result_q);
    p.issue(FFA_OP_SHR, FFA_SINGLE, 1'b0, 72'h10, 72'h0, {18'h4, 18'h0});
    cw("shr", 72'h1, result_q);
    p.issue(FFA_OP_CMP, FFA_SINGLE, 1'b0, 72'h1, 72'h1, {18'h2a5a5, 9'h1c3, 9'h0ad});
    cw("decode", {38'h0, 18'h2a5a5, 9'h1c3, 1'b1, 6'h2d}, {38'h0, instr_q});
    complete_run;
  end
endmodule : tb_ffa_datapath
